//--- hw/tm_monitor.v
// Temperature monitor core: serial slave, register map, limit flags and alarm outputs
`timescale 1ns/10ps
`include "tm_consts.vh"
module tm_monitor #(
  parameter [31:0] TIMEOUT_CYCLES   = `TM_TIMEOUT_MS * `TM_CLK_KHZ,
  parameter [31:0] CONV_BASE_CYCLES = `TM_CONV_BASE_MS * `TM_CLK_KHZ,
  parameter [7:0]  MAKER_CODE       = 8'h5A, // Arbitrary value
  parameter [7:0]  REVISION_CODE    = 8'h01  // Arbitrary value
) (
  input  wire       core_clk,
  input  wire       srst,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire [7:0] adc_data,
  input  wire       adc_valid,
  output reg        conv_start,
  output reg        conv_abort,
  output reg        range_extended,
  output reg        alert_out_n,
  output reg        overtemp_out_n
);

  localparam [2:0] S_IDLE     = 3'd0;
  localparam [2:0] S_ADDR     = 3'd1;
  localparam [2:0] S_ADDR_ACK = 3'd2;
  localparam [2:0] S_WR_BYTE  = 3'd3;
  localparam [2:0] S_WR_ACK   = 3'd4;
  localparam [2:0] S_RD_BYTE  = 3'd5;
  localparam [2:0] S_RD_ACK   = 3'd6;

  reg  [7:0]  register_pointer;
  reg  [7:0]  temperature_value;
  reg  [7:0]  device_setup;
  reg  [7:0]  sample_rate_select;
  reg  [7:0]  upper_temp_limit;
  reg  [7:0]  lower_temp_limit;
  reg  [7:0]  overtemp_limit;
  reg  [7:0]  overtemp_hysteresis;
  reg  [7:0]  fault_count_and_timeout;
  reg         high_flag;
  reg         low_flag;
  reg         overtemp_trip_flag;
  reg         second_trip_state;
  reg         alarm_latch;
  reg         busy;
  reg  [2:0]  run_count;
  reg  [31:0] rate_count;
  reg  [2:0]  state;
  reg  [2:0]  bit_count;
  reg  [7:0]  shift_in;
  reg  [7:0]  shift_out;
  reg         byte_done;
  reg         first_byte;
  reg         is_read;
  reg         is_ara;
  reg         master_nack;
  reg  [31:0] idle_count;
  reg         wr_stb;
  reg  [7:0]  wr_addr;
  reg  [7:0]  wr_data;
  reg         status_rd;
  reg         ara_done;
  reg  [7:0]  rd_data;
  reg  [2:0]  need_count;
  reg  [3:0]  rate_code;
  reg         scl_d;
  reg         sda_d;
  wire [1:0]  pins_sync;
  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;
  wire        alarm_output_mask;
  wire        standby;
  wire        shared_pin_function_select;
  wire        high_now;
  wire        low_now;
  wire        ot_release;
  wire        t2_release;
  wire        meas_done;
  wire        meas_out;
  wire        meas_high;
  wire        meas_low;
  wire [2:0]  run_next;
  wire        trip;
  wire [31:0] rate_interval;
  wire        oneshot_req;
  wire        periodic_req;
  wire        enter_standby;
  wire [7:0]  status_byte;

  tm_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_sync)
  );

  assign scl_s     = pins_sync[1];
  assign sda_s     = pins_sync[0];
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  assign alarm_output_mask          = device_setup[`TM_CFG_MASK];
  assign standby                    = device_setup[`TM_CFG_STANDBY];
  assign shared_pin_function_select = device_setup[`TM_CFG_PINSEL];

  assign high_now   = temperature_value > upper_temp_limit;
  assign low_now    = temperature_value <= lower_temp_limit;
  assign ot_release = ({1'b0, temperature_value} + {1'b0, overtemp_hysteresis})
                      <= {1'b0, overtemp_limit};
  assign t2_release = ({1'b0, temperature_value} + {1'b0, overtemp_hysteresis})
                      <= {1'b0, upper_temp_limit};

  assign meas_done = adc_valid & busy;
  assign meas_high = adc_data > upper_temp_limit;
  assign meas_low  = adc_data <= lower_temp_limit;
  assign meas_out  = meas_high | meas_low;
  assign run_next  = (run_count == 3'd4) ? 3'd4 : run_count + 3'd1;
  assign trip      = meas_done & meas_out & (run_next >= need_count);

  assign rate_interval = CONV_BASE_CYCLES >> rate_code;
  assign periodic_req  = ~standby & (rate_count >= rate_interval - 32'd1);
  assign oneshot_req   = wr_stb & (wr_addr == `TM_WR_ONESHOT) & standby;
  assign enter_standby = wr_stb & (wr_addr == `TM_WR_SETUP) & ~standby
                         & wr_data[`TM_CFG_STANDBY];

  assign status_byte = {busy,
                        shared_pin_function_select ? second_trip_state : high_flag,
                        shared_pin_function_select ? 1'b0 : low_flag,
                        4'h0, overtemp_trip_flag};

  // Consecutive count decode and rate code clamp
  always @* begin
    case (fault_count_and_timeout[3:1])
      3'b001:  need_count = 3'd2;
      3'b011:  need_count = 3'd3;
      3'b111:  need_count = 3'd4;
      default: need_count = 3'd1;
    endcase
    if (sample_rate_select[3:0] > `TM_RATE_MAX_CODE) begin
      rate_code = `TM_RATE_MAX_CODE;
    end else begin
      rate_code = sample_rate_select[3:0];
    end
  end

  // Read decode at the retained pointer
  always @* begin
    case (register_pointer)
      `TM_RD_TEMP:   rd_data = temperature_value;
      `TM_RD_STATUS: rd_data = status_byte;
      `TM_RD_SETUP:  rd_data = device_setup;
      `TM_RD_RATE:   rd_data = sample_rate_select;
      `TM_RD_HIGH:   rd_data = upper_temp_limit;
      `TM_RD_LOW:    rd_data = lower_temp_limit;
      `TM_OT_LIMIT:  rd_data = overtemp_limit;
      `TM_OT_HYST:   rd_data = overtemp_hysteresis;
      `TM_FAULT_CNT: rd_data = fault_count_and_timeout;
      `TM_RD_MAKER:  rd_data = MAKER_CODE;
      `TM_RD_REV:    rd_data = REVISION_CODE;
      default:       rd_data = 8'h00;
    endcase
  end

  // Serial slave
  always @(posedge core_clk) begin
    if (srst) begin
      scl_d            <= 1'b1;
      sda_d            <= 1'b1;
      state            <= S_IDLE;
      bit_count        <= 3'd0;
      shift_in         <= 8'h00;
      shift_out        <= 8'h00;
      byte_done        <= 1'b0;
      first_byte       <= 1'b0;
      is_read          <= 1'b0;
      is_ara           <= 1'b0;
      master_nack      <= 1'b0;
      idle_count       <= 32'd0;
      sda_out          <= 1'b0;
      sda_oe           <= 1'b0;
      wr_stb           <= 1'b0;
      wr_addr          <= 8'h00;
      wr_data          <= 8'h00;
      status_rd        <= 1'b0;
      ara_done         <= 1'b0;
      register_pointer <= `TM_RST_PTR;
    end else begin
      scl_d     <= scl_s;
      sda_d     <= sda_s;
      wr_stb    <= 1'b0;
      status_rd <= 1'b0;
      ara_done  <= 1'b0;
      if (scl_s != scl_d || sda_s != sda_d || state == S_IDLE) begin
        idle_count <= 32'd0;
      end else if (idle_count != TIMEOUT_CYCLES) begin
        idle_count <= idle_count + 32'd1;
      end
      if (bus_start) begin
        state     <= S_ADDR;
        bit_count <= 3'd0;
        byte_done <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (fault_count_and_timeout[`TM_FC_TIMEOUT_EN]
                   && idle_count == TIMEOUT_CYCLES) begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == S_ADDR || state == S_WR_BYTE) begin
          shift_in  <= {shift_in[6:0], sda_s};
          bit_count <= bit_count + 3'd1;
          byte_done <= (bit_count == 3'd7);
        end else if (state == S_RD_ACK) begin
          master_nack <= sda_s;
        end
      end else if (scl_fall) begin
        case (state)
          S_ADDR: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              is_read   <= shift_in[0];
              is_ara    <= (shift_in[7:1] == `TM_ARA_ADDR);
              if (shift_in[7:1] == `TM_DEV_ADDR
                  || (shift_in[7:1] == `TM_ARA_ADDR && shift_in[0]
                      && alarm_latch && !shared_pin_function_select)) begin
                sda_oe <= 1'b1;
                state  <= S_ADDR_ACK;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ADDR_ACK: begin
            bit_count <= 3'd0;
            if (is_read) begin
              state <= S_RD_BYTE;
              if (is_ara) begin
                shift_out <= {`TM_DEV_ADDR, 1'b1};
                sda_oe    <= 1'b0;
                ara_done  <= 1'b1;
              end else begin
                shift_out <= rd_data;
                sda_oe    <= ~rd_data[7];
                status_rd <= (register_pointer == `TM_RD_STATUS);
              end
            end else begin
              sda_oe     <= 1'b0;
              first_byte <= 1'b1;
              state      <= S_WR_BYTE;
            end
          end
          S_WR_BYTE: begin
            if (byte_done) begin
              byte_done  <= 1'b0;
              sda_oe     <= 1'b1;
              state      <= S_WR_ACK;
              first_byte <= 1'b0;
              if (first_byte) begin
                register_pointer <= shift_in;
              end else begin
                wr_stb  <= 1'b1;
                wr_addr <= register_pointer;
                wr_data <= shift_in;
              end
            end
          end
          S_WR_ACK: begin
            sda_oe <= 1'b0;
            state  <= S_WR_BYTE;
          end
          S_RD_BYTE: begin
            bit_count <= bit_count + 3'd1;
            if (bit_count == 3'd7) begin
              sda_oe <= 1'b0;
              state  <= S_RD_ACK;
            end else begin
              shift_out <= {shift_out[6:0], 1'b0};
              sda_oe    <= ~shift_out[6];
            end
          end
          S_RD_ACK: begin
            bit_count <= 3'd0;
            if (master_nack) begin
              state <= S_IDLE;
            end else begin
              state     <= S_RD_BYTE;
              shift_out <= rd_data;
              sda_oe    <= ~rd_data[7];
              status_rd <= (register_pointer == `TM_RD_STATUS) && !is_ara;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Register file and conversion scheduling
  always @(posedge core_clk) begin
    if (srst) begin
      temperature_value       <= `TM_RST_TEMP;
      device_setup            <= `TM_RST_SETUP;
      sample_rate_select      <= `TM_RST_RATE;
      upper_temp_limit        <= `TM_RST_HIGH;
      lower_temp_limit        <= `TM_RST_LOW;
      overtemp_limit          <= `TM_RST_OT_LIMIT;
      overtemp_hysteresis     <= `TM_RST_OT_HYST;
      fault_count_and_timeout <= `TM_RST_FAULT_CNT;
      busy                    <= 1'b0;
      rate_count              <= 32'd0;
      run_count               <= 3'd0;
      conv_start              <= 1'b0;
      conv_abort              <= 1'b0;
      range_extended          <= 1'b0;
    end else begin
      conv_start     <= 1'b0;
      conv_abort     <= 1'b0;
      range_extended <= device_setup[`TM_CFG_RANGE];
      if (wr_stb) begin
        case (wr_addr)
          `TM_WR_SETUP:  device_setup            <= wr_data;
          `TM_WR_RATE:   sample_rate_select      <= wr_data;
          `TM_WR_HIGH:   upper_temp_limit        <= wr_data;
          `TM_WR_LOW:    lower_temp_limit        <= wr_data;
          `TM_OT_LIMIT:  overtemp_limit          <= wr_data;
          `TM_OT_HYST:   overtemp_hysteresis     <= wr_data;
          `TM_FAULT_CNT: fault_count_and_timeout <= wr_data;
          default:       ;
        endcase
      end
      if (standby || periodic_req) begin
        rate_count <= 32'd0;
      end else begin
        rate_count <= rate_count + 32'd1;
      end
      if (enter_standby && busy) begin
        busy       <= 1'b0;
        conv_abort <= 1'b1;
      end else if (meas_done) begin
        busy              <= 1'b0;
        temperature_value <= adc_data;
      end else if (!busy && (periodic_req || oneshot_req)) begin
        busy       <= 1'b1;
        conv_start <= 1'b1;
      end
      if (meas_done && !enter_standby) begin
        run_count <= meas_out ? run_next : 3'd0;
      end
    end
  end

  // Limit flags, alarm latch and output pins
  always @(posedge core_clk) begin
    if (srst) begin
      high_flag          <= 1'b0;
      low_flag           <= 1'b0;
      overtemp_trip_flag <= 1'b0;
      second_trip_state  <= 1'b0;
      alarm_latch        <= 1'b0;
      alert_out_n        <= 1'b1;
      overtemp_out_n     <= 1'b1;
    end else begin
      if (temperature_value > overtemp_limit) begin
        overtemp_trip_flag <= 1'b1;
      end else if (ot_release) begin
        overtemp_trip_flag <= 1'b0;
      end
      if (high_now) begin
        second_trip_state <= 1'b1;
      end else if (t2_release) begin
        second_trip_state <= 1'b0;
      end
      if (trip && meas_high && !shared_pin_function_select) begin
        high_flag <= 1'b1;
      end else if (status_rd && !high_now) begin
        high_flag <= 1'b0;
      end
      if (trip && meas_low && !shared_pin_function_select) begin
        low_flag <= 1'b1;
      end else if (status_rd && !low_now) begin
        low_flag <= 1'b0;
      end
      if (trip && !shared_pin_function_select) begin
        alarm_latch <= 1'b1;
      end else if ((status_rd || ara_done) && !high_now && !low_now) begin
        alarm_latch <= 1'b0;
      end
      overtemp_out_n <= ~overtemp_trip_flag;
      if (shared_pin_function_select) begin
        alert_out_n <= ~second_trip_state;
      end else begin
        alert_out_n <= ~(alarm_latch & ~alarm_output_mask);
      end
    end
  end

endmodule

//--- hw/tm_consts.vh
// Register offsets, field positions, reset values and timing counts of the monitor
`ifndef TM_CONSTS_VH
`define TM_CONSTS_VH

`define TM_DEV_ADDR        7'h4C
`define TM_ARA_ADDR        7'h0C

`define TM_RD_TEMP         8'h00
`define TM_RD_STATUS       8'h02
`define TM_RD_SETUP        8'h03
`define TM_RD_RATE         8'h04
`define TM_RD_HIGH         8'h05
`define TM_RD_LOW          8'h06
`define TM_WR_SETUP        8'h09
`define TM_WR_RATE         8'h0A
`define TM_WR_HIGH         8'h0B
`define TM_WR_LOW          8'h0C
`define TM_WR_ONESHOT      8'h0F
`define TM_OT_LIMIT        8'h20
`define TM_OT_HYST         8'h21
`define TM_FAULT_CNT       8'h22
`define TM_RD_MAKER        8'hFE
`define TM_RD_REV          8'hFF

`define TM_ST_BUSY         7
`define TM_ST_HIGH         6
`define TM_ST_LOW          5
`define TM_ST_OT           0
`define TM_CFG_MASK        7
`define TM_CFG_STANDBY     6
`define TM_CFG_PINSEL      5
`define TM_CFG_RANGE       2
`define TM_FC_TIMEOUT_EN   7

`define TM_RST_TEMP        8'h00
`define TM_RST_SETUP       8'h00
`define TM_RST_RATE        8'h08
`define TM_RST_HIGH        8'h55
`define TM_RST_LOW         8'h00
`define TM_RST_OT_LIMIT    8'h55
`define TM_RST_OT_HYST     8'h0A
`define TM_RST_FAULT_CNT   8'h01
`define TM_RST_PTR         8'h00

`define TM_RATE_MAX_CODE   4'hA
`define TM_CLK_KHZ         32'd200000
`define TM_TIMEOUT_MS      32'd25
`define TM_CONV_BASE_MS    32'd16000

`endif

//--- hw/tm_sync2.v
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module tm_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  always @(posedge core_clk) begin
    if (srst) begin
      stage1   <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

//--- test/tm_monitor_chk.sv
// Port-level assertion checker for the monitor core
`timescale 1ns/10ps
module tm_monitor_chk (
  input wire       core_clk,
  input wire       srst,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire [7:0] adc_data,
  input wire       adc_valid,
  input wire       conv_start,
  input wire       conv_abort,
  input wire       range_extended,
  input wire       alert_out_n,
  input wire       overtemp_out_n
);
  // Overtemp limit and hysteresis stay at reset values in the bench
  reg        busy_m;
  wire       take = adc_valid && busy_m;
  wire [8:0] t_h  = {1'b0, adc_data} + 9'h00A;

  always @(posedge core_clk) begin
    if (srst || adc_valid || conv_abort) begin
      busy_m <= 1'b0;
    end else if (conv_start) begin
      busy_m <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_reset_idle: assert property ($fell(srst) |-> !sda_oe && alert_out_n && overtemp_out_n)
    else $error("outputs not idle after reset");
  a_sda_only_low: assert property (!sda_out)
    else $error("data line driven high");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_drive_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("data drive too short");
  a_no_restart: assert property (conv_start |-> !busy_m)
    else $error("conversion started while busy");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_ot_trip: assert property (take && adc_data > 8'h55 |-> ##[1:6] !overtemp_out_n)
    else $error("overtemp not asserted");
  a_ot_hold: assert property (take && t_h > 9'h055 && !overtemp_out_n |=> !overtemp_out_n [*6])
    else $error("overtemp released inside hysteresis");
  a_ot_clear: assert property (take && t_h <= 9'h055 |-> ##[1:6] overtemp_out_n)
    else $error("overtemp not released");

  c_hot: cover property (take && adc_data > 8'h55);
  c_alert: cover property ($fell(alert_out_n));
  c_ack: cover property ($rose(sda_oe));
endmodule

bind tm_monitor tm_monitor_chk tm_monitor_chk_inst (.core_clk, .srst, .scl_in, .sda_in,
  .sda_out, .sda_oe, .adc_data, .adc_valid, .conv_start, .conv_abort, .range_extended,
  .alert_out_n, .overtemp_out_n);

//--- test/tm_bm.sv
// Serial bus master model with a stopped clock between frames
`timescale 1ns/10ps
module tm_bm (
  input wire core_clk,
  input wire sda_w,
  output reg scl,
  output reg sda_m
);
  localparam Q = 8;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task wq;
    begin
      repeat (Q) @(negedge core_clk);
    end
  endtask
  task xbit(input b, output r);
    begin
      wq;
      sda_m = b;
      wq;
      scl = 1'b1;
      wq;
      r = sda_w;
      wq;
      scl = 1'b0;
    end
  endtask
  task xstart;
    begin
      wq;
      sda_m = 1'b0;
      wq;
      scl = 1'b0;
    end
  endtask
  task xstop;
    begin
      wq;
      sda_m = 1'b0;
      wq;
      scl = 1'b1;
      wq;
      sda_m = 1'b1;
      wq;
    end
  endtask
  task put(input [7:0] b, output ack);
    reg r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        xbit(b[i], r);
      end
      xbit(1'b1, r);
      ack = !r;
    end
  endtask
  task get(input nack, output [7:0] b);
    reg r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        xbit(1'b1, r);
        b[i] = r;
      end
      xbit(nack, r);
    end
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the monitor core
`timescale 1ns/10ps
`include "tm_consts.vh"
module testbench;
  reg        core_clk;
  reg        srst;
  reg        adc_valid;
  reg  [7:0] adc_data;
  reg  [7:0] adc_next;
  reg  [7:0] rd;
  reg        ack;
  wire       scl;
  wire       sda_m;
  wire       sda_oe;
  wire       alert_out_n;
  wire       overtemp_out_n;
  wire       conv_start;
  wire       range_extended;
  wire       sda_w = sda_m & ~sda_oe;
  integer    adc_cnt;
  integer    conv_count;
  integer    bad_count;
  integer    n_checks;
  integer    i;
  integer    c0;
  logic [15:0] tbl [0:8] = '{16'h0408, 16'h0555, 16'h0600, 16'h2055, 16'h210A,
                             16'h2201, 16'h0300, 16'h1000, 16'h0B00};

  tm_monitor #(.TIMEOUT_CYCLES(32'd2000), .CONV_BASE_CYCLES(32'd20000)) tm_monitor_inst (
    .core_clk(core_clk), .srst(srst), .scl_in(scl), .sda_in(sda_w), .sda_out(),
    .sda_oe(sda_oe), .adc_data(adc_data), .adc_valid(adc_valid), .conv_start(conv_start),
    .conv_abort(), .range_extended(range_extended), .alert_out_n(alert_out_n),
    .overtemp_out_n(overtemp_out_n));
  tm_bm tm_bm_inst (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Converter answers five cycles after each start
  always @(negedge core_clk) begin
    adc_valid <= 1'b0;
    adc_data <= ~adc_next;
    if (conv_start) begin
      adc_cnt <= 5;
      conv_count <= conv_count + 1;
    end else if (adc_cnt == 1) begin
      adc_valid <= 1'b1;
      adc_data <= adc_next;
      adc_cnt <= 0;
    end else if (adc_cnt > 1) begin
      adc_cnt <= adc_cnt - 1;
    end
  end

  task chk8(input string n, input [7:0] e, input [7:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[ERR] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  task xfer(input [7:0] p, input [7:0] d, input two);
    begin
      tm_bm_inst.xstart;
      tm_bm_inst.put({`TM_DEV_ADDR, 1'b0}, ack);
      tm_bm_inst.put(p, ack);
      if (two) begin
        tm_bm_inst.put(d, ack);
      end
      tm_bm_inst.xstop;
      chk8("write ack", 8'h01, {7'h0, ack});
    end
  endtask
  task rc(output [7:0] d);
    begin
      tm_bm_inst.xstart;
      tm_bm_inst.put({`TM_DEV_ADDR, 1'b1}, ack);
      tm_bm_inst.get(1'b1, d);
      tm_bm_inst.xstop;
    end
  endtask
  task rr(input [7:0] p, input [7:0] e, input string n);
    begin
      xfer(p, 8'h00, 1'b0);
      rc(rd);
      chk8(n, e, rd);
    end
  endtask
  task os(input [7:0] t);
    integer c;
    integer k;
    begin
      c = conv_count;
      adc_next = t;
      xfer(`TM_WR_ONESHOT, 8'hA5, 1'b1);
      for (k = 0; k < 200 && adc_cnt != 0; k = k + 1) begin
        @(negedge core_clk);
      end
      if (k == 200) begin
        bad_count = bad_count + 1;
        final_report;
      end
      repeat (8) @(negedge core_clk);
      chk8("one-shot count", c[7:0] + 8'h01, conv_count[7:0]);
    end
  endtask

  initial begin
    srst = 1'b1;
    adc_valid = 1'b0;
    adc_data = 8'h00;
    adc_next = 8'h20;
    adc_cnt = 0;
    conv_count = 0;
    bad_count = 0;
    n_checks = 0;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    rc(rd);
    chk8("temp at reset pointer", 8'h20, rd);
    chk8("run conversions", 8'h01, {7'h0, conv_count > 0});
    for (i = 0; i < 9; i = i + 1) begin
      rr(tbl[i][15:8], tbl[i][7:0], "reset value");
    end
    tm_bm_inst.xstart;
    tm_bm_inst.put(8'h9A, ack);
    tm_bm_inst.xstop;
    chk8("foreign address ack", 8'h00, {7'h0, ack});
    xfer(`TM_WR_SETUP, 8'h40, 1'b1);
    xfer(`TM_WR_HIGH, 8'h50, 1'b1);
    rr(`TM_RD_HIGH, 8'h50, "high limit");
    rr(`TM_RD_SETUP, 8'h40, "setup");
    c0 = conv_count;
    repeat (400) @(negedge core_clk);
    chk8("standby conversions", c0[7:0], conv_count[7:0]);
    os(8'h60);
    chk8("alert", 8'h00, {7'h0, alert_out_n});
    chk8("overtemp", 8'h00, {7'h0, overtemp_out_n});
    rr(`TM_RD_STATUS, 8'h41, "status");
    rr(`TM_RD_STATUS, 8'h41, "status held");
    chk8("alert held", 8'h00, {7'h0, alert_out_n});
    rr(`TM_WR_ONESHOT, 8'h00, "one-shot data");
    os(8'h50);
    chk8("overtemp in band", 8'h00, {7'h0, overtemp_out_n});
    chk8("alert latched", 8'h00, {7'h0, alert_out_n});
    rr(`TM_RD_STATUS, 8'h41, "status sticky");
    chk8("alert released", 8'h01, {7'h0, alert_out_n});
    rr(`TM_RD_STATUS, 8'h01, "status cleared");
    os(8'h4B);
    chk8("overtemp released", 8'h01, {7'h0, overtemp_out_n});
    xfer(`TM_WR_LOW, 8'h30, 1'b1);
    os(8'h30);
    rr(`TM_RD_STATUS, 8'h20, "low flag");
    xfer(`TM_WR_SETUP, 8'hC0, 1'b1);
    chk8("masked alert", 8'h01, {7'h0, alert_out_n});
    xfer(`TM_WR_SETUP, 8'h44, 1'b1);
    chk8("unmasked alert", 8'h00, {7'h0, alert_out_n});
    chk8("range select", 8'h01, {7'h0, range_extended});
    xfer(`TM_WR_LOW, 8'h00, 1'b1);
    os(8'h40);
    tm_bm_inst.xstart;
    tm_bm_inst.put({`TM_ARA_ADDR, 1'b1}, ack);
    tm_bm_inst.get(1'b1, rd);
    tm_bm_inst.xstop;
    chk8("alert response ack", 8'h01, {7'h0, ack});
    chk8("alert response", {`TM_DEV_ADDR, 1'b1}, rd);
    chk8("alert after response", 8'h01, {7'h0, alert_out_n});
    rr(`TM_RD_STATUS, 8'h20, "low flag sticky");
    chk8("alert cleared", 8'h01, {7'h0, alert_out_n});
    xfer(`TM_FAULT_CNT, 8'h03, 1'b1);
    os(8'h60);
    os(8'h40);
    os(8'h60);
    chk8("filtered alert", 8'h01, {7'h0, alert_out_n});
    os(8'h60);
    chk8("alert after two", 8'h00, {7'h0, alert_out_n});
    xfer(`TM_WR_SETUP, 8'h60, 1'b1);
    chk8("second trip set", 8'h00, {7'h0, alert_out_n});
    chk8("range cleared", 8'h00, {7'h0, range_extended});
    os(8'h4A);
    chk8("second trip band", 8'h00, {7'h0, alert_out_n});
    os(8'h45);
    chk8("second trip clear", 8'h01, {7'h0, alert_out_n});
    xfer(`TM_FAULT_CNT, 8'h80, 1'b1);
    tm_bm_inst.xstart;
    tm_bm_inst.put({`TM_DEV_ADDR, 1'b0}, ack);
    for (i = 7; i >= 0; i = i - 1) begin
      tm_bm_inst.xbit(1'b0, ack);
    end
    repeat (8) @(negedge core_clk);
    chk8("ack before timeout", 8'h01, {7'h0, sda_oe});
    repeat (2100) @(negedge core_clk);
    chk8("timeout release", 8'h00, {7'h0, sda_oe});
    tm_bm_inst.xstop;
    final_report;
  end
endmodule
